// ### design/cbt_cfg.svh
// register offsets, field positions, reset values, response codes and buffer indices
// assumes a 32-bit word-aligned register bus
`ifndef CBT_CFG_SVH
`define CBT_CFG_SVH

`define CBT_OFS_PRESCALE 8'h00
`define CBT_OFS_SEGMENTS 8'h04
`define CBT_OFS_CONTROL 8'h08
`define CBT_OFS_COUNTER 8'h0C
`define CBT_OFS_SHARED_MASK 8'h10
`define CBT_OFS_MASK14 8'h14
`define CBT_OFS_MASK15 8'h18
`define CBT_OFS_STAMP 8'h1C

`define CBT_RJW_HI 7
`define CBT_RJW_LO 6
`define CBT_PHASE_SEGMENT_FIRST_HI 5
`define CBT_PHASE_SEGMENT_FIRST_LO 3
`define CBT_PHASE_SEGMENT_SECOND_HI 2
`define CBT_PHASE_SEGMENT_SECOND_LO 0
`define CBT_CTRL_SYNC_BIT 3
`define CBT_PROP_HI 2
`define CBT_PROP_LO 0

`define CBT_MASK_STD_HI 31
`define CBT_MASK_STD_LO 21
`define CBT_MASK_RTR_HI 20
`define CBT_MASK_IDE_BIT 19
`define CBT_MASK_EXT_HI 18
`define CBT_MASK_EXT_LO 1

`define CBT_PRESCALE_RST 8'h00
`define CBT_SEGMENTS_RST 8'h00
`define CBT_CONTROL_RST 4'h0
`define CBT_COUNTER_RST 16'h0000
`define CBT_MASK_RST 29'h1FFFFFFF

`define CBT_RESP_OKAY 2'h0
`define CBT_RESP_SLVERR 2'h2
`define CBT_LAST_SHARED_BUF 4'hD
`define CBT_BUF_FOURTEEN 4'hE
`define CBT_BUF_SYNC 4'h0

`endif

// ### design/cbt_pkg.sv
// types shared by the bit timing, time stamp and filter block
// assumes nothing beyond the config header
package cbt_pkg;

    typedef enum logic [3:0] {
        CBT_SYNC = 4'h1,
        CBT_PROP = 4'h2,
        CBT_PH1 = 4'h4,
        CBT_PH2 = 4'h8
    } cbt_seg_t;

endpackage

// ### design/cbt_top.sv
// can bit timing, free running bit counter, time stamp and acceptance
// masks, with an axi4-lite register slave; assumes synchronous inputs
// from the frame engine and the rx pin edge detector
`timescale 1ns/1ps
`include "cbt_cfg.svh"

module cbt_top import cbt_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic bus_edge,
    input wire logic in_frame,
    input wire logic id_field_start,
    input wire logic frame_ok,
    input wire logic frame_was_rx,
    input wire logic [3:0] frame_buf_index,
    input wire logic rx_check,
    input wire logic [28:0] rx_id,
    input wire logic rx_ide,
    input wire logic rx_rtr,
    input wire logic [3:0] cmp_buf_index,
    input wire logic [28:0] cmp_buf_id,
    input wire logic cmp_buf_ide,
    output logic tq_tick,
    output logic bit_tick,
    output logic [15:0] bit_counter,
    output logic stamp_write,
    output logic [3:0] stamp_index,
    output logic [15:0] stamp_data,
    output logic accept_valid,
    output logic accept
);

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // reserved mask bits: ide location forced one, rtr locations zero
    function automatic logic [31:0] mask_view(input logic [28:0] m);
        return {m[28:18], 1'b0, 1'b1, m[17:0], 1'b0};
    endfunction

    function automatic logic [2:0] jump(input logic [5:0] err,
        input logic [1:0] resync_jump_width);
        logic [2:0] lim;
        lim = {1'b0, resync_jump_width} + 3'h1;
        if (err > {3'h0, lim}) begin
            return lim;
        end
        return err[2:0];
    endfunction

    logic [7:0] serial_clock_prescale;
    logic [7:0] bit_timing_segments;
    logic [3:0] control;
    logic [28:0] shared_accept_mask;
    logic [28:0] buffer_fourteen_mask;
    logic [28:0] buffer_fifteen_mask;
    logic [15:0] captured;
    logic aw_full, w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic wr_hit;
    logic [31:0] mg_prescale, mg_segments, mg_control, mg_counter;
    logic [31:0] mg_shared, mg_m14, mg_m15;
    logic [31:0] view_shared, view_m14, view_m15;

    // byte-merged write values, sliced where they are stored
    assign mg_prescale = merge({24'h0, serial_clock_prescale}, w_data,
        w_strb);
    assign mg_segments = merge({24'h0, bit_timing_segments}, w_data,
        w_strb);
    assign mg_control = merge({28'h0, control}, w_data, w_strb);
    assign mg_counter = merge({16'h0, bit_counter}, w_data, w_strb);
    assign view_shared = mask_view(shared_accept_mask);
    assign view_m14 = mask_view(buffer_fourteen_mask);
    assign view_m15 = mask_view(buffer_fifteen_mask);
    assign mg_shared = merge(view_shared, w_data, w_strb);
    assign mg_m14 = merge(view_m14, w_data, w_strb);
    assign mg_m15 = merge(view_m15, w_data, w_strb);

    // axi4-lite write path: address and data taken in either order
    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;
    assign do_write = aw_full && w_full && !s_axi_bvalid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_full <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_full <= 1'b0;
            end
        end
    end

    always_comb begin
        case (aw_addr)
            `CBT_OFS_PRESCALE, `CBT_OFS_SEGMENTS, `CBT_OFS_CONTROL,
            `CBT_OFS_COUNTER, `CBT_OFS_SHARED_MASK, `CBT_OFS_MASK14,
            `CBT_OFS_MASK15, `CBT_OFS_STAMP: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CBT_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `CBT_RESP_OKAY : `CBT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_clock_prescale <= `CBT_PRESCALE_RST;
            bit_timing_segments <= `CBT_SEGMENTS_RST;
            control <= `CBT_CONTROL_RST;
        end else if (do_write) begin
            case (aw_addr)
                `CBT_OFS_PRESCALE: serial_clock_prescale <= mg_prescale[7:0];
                `CBT_OFS_SEGMENTS: bit_timing_segments <= mg_segments[7:0];
                `CBT_OFS_CONTROL: control <= mg_control[3:0];
                default: ;
            endcase
        end
    end

    // acceptance masks; reserved positions are not stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shared_accept_mask <= `CBT_MASK_RST;
            buffer_fourteen_mask <= `CBT_MASK_RST;
            buffer_fifteen_mask <= `CBT_MASK_RST;
        end else if (do_write) begin
            case (aw_addr)
                `CBT_OFS_SHARED_MASK: shared_accept_mask <=
                    {mg_shared[31:21], mg_shared[18:1]};
                `CBT_OFS_MASK14: buffer_fourteen_mask <=
                    {mg_m14[31:21], mg_m14[18:1]};
                `CBT_OFS_MASK15: buffer_fifteen_mask <=
                    {mg_m15[31:21], mg_m15[18:1]};
                default: ;
            endcase
        end
    end

    // axi4-lite read path
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CBT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `CBT_RESP_OKAY;
            case (s_axi_araddr)
                `CBT_OFS_PRESCALE: s_axi_rdata <=
                    {24'h0, serial_clock_prescale};
                `CBT_OFS_SEGMENTS: s_axi_rdata <=
                    {24'h0, bit_timing_segments};
                `CBT_OFS_CONTROL: s_axi_rdata <= {28'h0, control};
                `CBT_OFS_COUNTER: s_axi_rdata <=
                    {16'h0, bit_counter};
                `CBT_OFS_SHARED_MASK: s_axi_rdata <=
                    mask_view(shared_accept_mask);
                `CBT_OFS_MASK14: s_axi_rdata <=
                    mask_view(buffer_fourteen_mask);
                `CBT_OFS_MASK15: s_axi_rdata <=
                    mask_view(buffer_fifteen_mask);
                `CBT_OFS_STAMP: s_axi_rdata <= {16'h0, captured};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `CBT_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // serial clock: one tq enable every 2*(prescale+1) clocks
    logic [8:0] pre_cnt;
    logic [8:0] pre_last;
    assign pre_last = {serial_clock_prescale, 1'b1};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= 9'h000;
            tq_tick <= 1'b0;
        end else if (pre_cnt >= pre_last) begin
            pre_cnt <= 9'h000;
            tq_tick <= 1'b1;
        end else begin
            pre_cnt <= pre_cnt + 9'h001;
            tq_tick <= 1'b0;
        end
    end

    // bit timing segments built from time quanta
    cbt_seg_t seg;
    logic [4:0] seg_cnt;
    logic [2:0] ext;
    logic [2:0] shrink;
    logic [1:0] resync_jump_width;
    logic [2:0] phase_segment_first, phase_segment_second, prop;
    logic [3:0] ph1_last;
    logic [2:0] ph2_last;
    assign resync_jump_width = bit_timing_segments[`CBT_RJW_HI:`CBT_RJW_LO];
    assign phase_segment_first = bit_timing_segments[`CBT_PHASE_SEGMENT_FIRST_HI:`CBT_PHASE_SEGMENT_FIRST_LO];
    assign phase_segment_second = bit_timing_segments[`CBT_PHASE_SEGMENT_SECOND_HI:`CBT_PHASE_SEGMENT_SECOND_LO];
    assign prop = control[`CBT_PROP_HI:`CBT_PROP_LO];
    assign ph1_last = {1'b0, phase_segment_first} + {1'b0, ext};
    assign ph2_last = (phase_segment_second > shrink) ? phase_segment_second - shrink : 3'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seg <= CBT_SYNC;
            seg_cnt <= 5'h00;
            ext <= 3'h0;
            shrink <= 3'h0;
            bit_tick <= 1'b0;
        end else begin
            bit_tick <= 1'b0;
            if (bus_edge && !in_frame && seg != CBT_SYNC) begin
                // hard sync: the edge quantum is the sync segment
                seg <= CBT_PROP;
                seg_cnt <= 5'h00;
                ext <= 3'h0;
                shrink <= 3'h0;
            end else begin
                if (bus_edge && in_frame && seg == CBT_PROP) begin
                    ext <= jump({1'b0, seg_cnt} + 6'h01, resync_jump_width);
                end else if (bus_edge && in_frame && seg == CBT_PH1) begin
                    ext <= jump({3'h0, prop} + {1'b0, seg_cnt} + 6'h02,
                        resync_jump_width);
                end else if (bus_edge && in_frame && seg == CBT_PH2) begin
                    shrink <= jump({3'h0, phase_segment_second} - {1'b0, seg_cnt} + 6'h01,
                        resync_jump_width);
                end
                // a resync edge must not swallow the quantum beside it
                if (tq_tick) begin
                    case (seg)
                        CBT_SYNC: begin
                            seg <= CBT_PROP;
                            seg_cnt <= 5'h00;
                        end
                        CBT_PROP: begin
                            if (seg_cnt == {2'h0, prop}) begin
                                seg <= CBT_PH1;
                                seg_cnt <= 5'h00;
                            end else begin
                                seg_cnt <= seg_cnt + 5'h01;
                            end
                        end
                        CBT_PH1: begin
                            if (seg_cnt >= {1'b0, ph1_last}) begin
                                seg <= CBT_PH2;
                                seg_cnt <= 5'h00;
                                ext <= 3'h0;
                            end else begin
                                seg_cnt <= seg_cnt + 5'h01;
                            end
                        end
                        CBT_PH2: begin
                            if (seg_cnt >= {2'h0, ph2_last}) begin
                                seg <= CBT_SYNC;
                                seg_cnt <= 5'h00;
                                shrink <= 3'h0;
                                bit_tick <= 1'b1;
                            end else begin
                                seg_cnt <= seg_cnt + 5'h01;
                            end
                        end
                        default: begin
                            seg <= CBT_SYNC;
                            seg_cnt <= 5'h00;
                        end
                    endcase
                end
            end
        end
    end

    // free running bit counter
    logic cnt_write, cnt_sync;
    assign cnt_write = do_write && aw_addr == `CBT_OFS_COUNTER;
    assign cnt_sync = control[`CBT_CTRL_SYNC_BIT] && frame_ok &&
        frame_was_rx && frame_buf_index == `CBT_BUF_SYNC;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_counter <= `CBT_COUNTER_RST;
        end else if (cnt_write) begin
            bit_counter <= mg_counter[15:0];
        end else if (cnt_sync) begin
            bit_counter <= `CBT_COUNTER_RST;
        end else if (bit_tick) begin
            bit_counter <= bit_counter + 16'h0001;
        end
    end

    // capture at identifier start, stamp after a good frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            captured <= 16'h0000;
        end else if (id_field_start) begin
            captured <= bit_counter;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stamp_write <= 1'b0;
            stamp_index <= 4'h0;
            stamp_data <= 16'h0000;
        end else begin
            stamp_write <= frame_ok;
            if (frame_ok) begin
                stamp_index <= frame_buf_index;
                stamp_data <= captured;
            end
        end
    end

    // acceptance filter
    logic [28:0] sel_mask;
    logic [28:0] eff_mask;
    always_comb begin
        if (cmp_buf_index <= `CBT_LAST_SHARED_BUF) begin
            sel_mask = shared_accept_mask;
        end else if (cmp_buf_index == `CBT_BUF_FOURTEEN) begin
            sel_mask = buffer_fourteen_mask;
        end else begin
            sel_mask = buffer_fifteen_mask;
        end
        // extended part only for extended frames
        eff_mask = rx_ide ? sel_mask : {sel_mask[28:18], 18'h00000};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            accept_valid <= 1'b0;
            accept <= 1'b0;
        end else begin
            accept_valid <= rx_check;
            accept <= rx_check && !rx_rtr &&
                rx_ide == cmp_buf_ide &&
                ((rx_id ^ cmp_buf_id) & eff_mask) == 29'h0;
        end
    end

    // checks
    sequence seq_ph1_last;
        seg == CBT_PH1 && tq_tick && !bus_edge &&
            seg_cnt >= {1'b0, ph1_last};
    endsequence

    sequence seq_frame_done;
        frame_ok ##1 stamp_write;
    endsequence

    AST_TQ_SPACING: assert property (@(posedge clk) disable iff (!rst_n)
        tq_tick |=> !tq_tick)
        else $error("tq ticks back to back");
    AST_PRESCALE_RESET: assert property (@(posedge clk)
        $rose(rst_n) |-> serial_clock_prescale == 8'h00)
        else $error("prescale not zero after reset");
    AST_JUMP_LIMIT: assert property (@(posedge clk) disable iff (!rst_n)
        ext <= {1'b0, resync_jump_width} + 3'h1 && shrink <= {1'b0, resync_jump_width} + 3'h1)
        else $error("resync jump beyond limit");
    AST_PH1_END: assert property (@(posedge clk) disable iff (!rst_n)
        seq_ph1_last |=> seg == CBT_PH2)
        else $error("phase one did not end");
    AST_PH2_END: assert property (@(posedge clk) disable iff (!rst_n)
        bit_tick |-> $past(seg) == CBT_PH2 && seg == CBT_SYNC)
        else $error("bit tick outside phase two end");
    AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!rst_n)
        bit_tick && !cnt_write && !cnt_sync |=>
        bit_counter == $past(bit_counter) + 16'h0001)
        else $error("counter did not step");
    AST_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
        id_field_start |=> captured == $past(bit_counter))
        else $error("counter not captured");
    AST_STAMP: assert property (@(posedge clk) disable iff (!rst_n)
        seq_frame_done |-> stamp_data == $past(captured))
        else $error("stamp data wrong");
    AST_SYNC_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_sync && !cnt_write |=> bit_counter == 16'h0000)
        else $error("sync did not clear counter");
    AST_NO_REMOTE: assert property (@(posedge clk) disable iff (!rst_n)
        accept |-> $past(rx_check) && !$past(rx_rtr))
        else $error("remote frame accepted");
    AST_MASK_FIXED: assert property (@(posedge clk) disable iff (!rst_n)
        view_shared[19] && !view_m14[20] && !view_m15[0])
        else $error("reserved mask bits wrong");

endmodule

// ### testbench/cbt_frame_model.sv
// frame engine model: one frame per go pulse, resync edge inside
// assumes the clock and reset of the block under test
`timescale 1ns/1ps
module cbt_frame_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [3:0] buf_sel,
    output logic bus_edge,
    output logic in_frame,
    output logic id_field_start,
    output logic frame_ok,
    output logic frame_was_rx,
    output logic [3:0] frame_buf_index
);
    logic [8:0] ph;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph <= 9'h000;
        end else if (ph != 9'h000 || go) begin
            ph <= (ph == 9'h190) ? 9'h000 : ph + 9'h001;
        end
    end
    // hard sync edge just before the frame, one resync edge inside it
    assign bus_edge = (ph == 9'h001) || (ph == 9'h096);
    assign in_frame = (ph > 9'h001);
    assign id_field_start = (ph == 9'h03C);
    assign frame_ok = (ph == 9'h190);
    assign frame_was_rx = frame_ok;
    // index only valid beside frame_ok, scrambled otherwise
    assign frame_buf_index = frame_ok ? buf_sel : ~buf_sel;
endmodule

// ### testbench/tb_cbt_top.sv
// self-checking bench for the bit timing, time stamp and mask block
// assumes the frame engine model on the frame side
`timescale 1ns/1ps
module tb_cbt_top;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic [1:0] r;
    } cbt_reg_row_t;
    typedef struct packed {
        logic [3:0] i;
        logic [28:0] id;
        logic ide;
        logic rtr;
        logic [28:0] bid;
        logic bide;
        logic e;
    } cbt_flt_row_t;
    localparam logic [28:0] B = 29'h0ABCDEF1;
    localparam cbt_reg_row_t REGS [10] = '{
        '{8'h00, 32'hFF, 32'hFF, 2'h0},
        '{8'h00, 32'h01, 32'h01, 2'h0},
        '{8'h04, 32'h59, 32'h59, 2'h0},
        '{8'h08, 32'h02, 32'h02, 2'h0},
        '{8'h10, 32'h0, 32'h00080000, 2'h0},
        '{8'h14, 32'hFFFFFFFF, 32'hFFEFFFFE, 2'h0},
        '{8'h18, 32'hFFE00000, 32'hFFE80000, 2'h0},
        '{8'h14, 32'h00000001, 32'h00080000, 2'h0},
        '{8'h10, 32'hFFFFFFFF, 32'hFFEFFFFE, 2'h0},
        '{8'h20, 32'h12345678, 32'h0, 2'h2}};
    localparam cbt_flt_row_t FLT [10] = '{
        '{4'h3, B, 1'h0, 1'h0, B, 1'h0, 1'h1},
        '{4'h3, B ^ 29'h1, 1'h0, 1'h0, B, 1'h0, 1'h1},
        '{4'h3, B ^ 29'h1, 1'h1, 1'h0, B, 1'h1, 1'h0},
        '{4'h3, B, 1'h1, 1'h0, B, 1'h0, 1'h0},
        '{4'h3, B, 1'h0, 1'h1, B, 1'h0, 1'h0},
        '{4'hE, B ^ 29'h10000000, 1'h1, 1'h0, B, 1'h1, 1'h1},
        '{4'hE, B, 1'h1, 1'h0, B, 1'h0, 1'h0},
        '{4'hF, B ^ 29'h1, 1'h1, 1'h0, B, 1'h1, 1'h1},
        '{4'hF, B ^ 29'h40000, 1'h1, 1'h0, B, 1'h1, 1'h0},
        '{4'hD, B ^ 29'h20000, 1'h1, 1'h0, B, 1'h1, 1'h0}};
    logic clk, rst_n, go;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [3:0] s_axi_wstrb, frame_buf_index, buf_sel;
    logic bus_edge, in_frame, id_field_start, frame_ok, frame_was_rx;
    logic rx_check, rx_ide, rx_rtr, cmp_buf_ide, tq_tick, bit_tick;
    logic stamp_write, accept_valid, accept;
    logic [28:0] rx_id, cmp_buf_id;
    logic [3:0] cmp_buf_index, stamp_index;
    logic [15:0] bit_counter, stamp_data, cap;
    int err_count, num_checks, cyc, n;

    cbt_top uut (.*);
    cbt_frame_model fm (.*);

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            err_count++;
            wrap_up;
        end
    end
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task axi_rd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        q = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return tq_tick;
            1: return bit_tick;
            2: return id_field_start;
            default: return stamp_write;
        endcase
    endfunction
    // waits for the selected pulse, n holds the cycles spent
    task wt(input int w);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pick(w) !== 1'h1);
    endtask
    task periods(input int tq, input int bt);
        wt(0);
        wt(0);
        chk("tq_period", n, tq);
        wt(1);
        wt(1);
        chk("bit_period", n, bt);
    endtask
    task frame(input logic [3:0] b);
        @(posedge clk);
        go <= 1'h1;
        buf_sel <= b;
        @(posedge clk);
        go <= 1'h0;
        wt(2);
        cap = bit_counter;
        wt(3);
        chk("stamp_data", stamp_data, cap);
        chk("stamp_index", stamp_index, b);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        {rst_n, go, buf_sel, s_axi_awaddr, s_axi_araddr, s_axi_awvalid} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_wdata, rx_check, rx_ide, rx_rtr, cmp_buf_ide} = '0;
        {rx_id, cmp_buf_id, cmp_buf_index} = '0;
        s_axi_wstrb = 4'hF;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        // masks settle here, before any frame traffic
        foreach (REGS[k]) begin
            axi_wr(REGS[k].a, REGS[k].d);
            chk("bresp", r, REGS[k].r);
            axi_rd(REGS[k].a);
            chk("rdata", q, REGS[k].q);
            chk("rresp", r, REGS[k].r);
        end
        $display("register rows done");
        foreach (FLT[k]) begin
            @(posedge clk);
            rx_check <= 1'h1;
            {cmp_buf_index, rx_id, rx_ide, rx_rtr} <= FLT[k][65:31];
            {cmp_buf_id, cmp_buf_ide} <= FLT[k][30:1];
            @(posedge clk);
            rx_check <= 1'h0;
            @(posedge clk);
            chk("accept_valid", accept_valid, 1'h1);
            chk("accept", accept, FLT[k].e);
        end
        $display("filter rows done");
        periods(4, 40);
        wt(1);
        axi_wr(8'h0C, 32'hFFFF);
        wt(1);
        @(posedge clk);
        chk("wrap", bit_counter, 16'h0000);
        axi_rd(8'h0C);
        chk("counter_read", q, 32'h0);
        wt(1);
        @(posedge clk);
        chk("step", bit_counter, 16'h0001);
        $display("timing and counter done");
        frame(4'h5);
        axi_rd(8'h1C);
        chk("stamp_read", q, {16'h0000, cap});
        axi_wr(8'h08, 32'h0A);
        frame(4'h0);
        chk("sync_clear", bit_counter, 16'h0000);
        $display("frame tests done");
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        axi_rd(8'h00);
        chk("prescale_rst", q, 32'h0);
        axi_rd(8'h10);
        chk("mask_rst", q, 32'hFFEFFFFE);
        periods(2, 8);
        s_axi_wstrb <= 4'h8;
        axi_wr(8'h10, 32'h00000000);
        axi_rd(8'h10);
        chk("strobe_merge", q, 32'h00EFFFFE);
        $display("reset test done");
        wrap_up;
    end
endmodule
